//--- include/bwm_pkg.sv
// Shared constants, types and fixed-point helpers for the breaker wear monitor.
`default_nettype none
package bwm_pkg;

    localparam int CUR_W = 14;
    localparam int OPS_W = 18;
    localparam int LOG_W = 13;
    localparam int NUM_W = 26;
    localparam int CNT_W = 32;
    localparam int SEL_W = 3;

    localparam logic [OPS_W-1:0] OPS_LOW_RST    = 18'h0c350;
    localparam logic [OPS_W-1:0] OPS_HIGH_RST   = 18'h00064;
    localparam logic [OPS_W-1:0] ALARM1_THR_RST = 18'h003e8;
    localparam logic [OPS_W-1:0] ALARM2_THR_RST = 18'h00064;
    localparam logic [OPS_W-1:0] DEDUCT_ONE     = 18'h00001;
    localparam logic [OPS_W-1:0] DEDUCT_SAT     = 18'h3ffff;
    localparam logic [CUR_W-1:0] CUR_LOW_RST    = 14'h0064;
    localparam logic [CUR_W-1:0] CUR_HIGH_RST   = 14'h07d0;
    localparam logic [SEL_W-1:0] TRIP_SEL_RST   = 3'h0;
    localparam logic             SIDE_RST       = 1'b0;
    localparam logic [4:0]       DIV_LAST       = 5'h19;
    localparam logic [4:0]       EXP_INT_LIMIT  = 5'h12;
    localparam logic [CNT_W-1:0] CNT_ONE        = 32'h00000001;

    typedef enum logic [2:0] {
        BWM_MODE_ON           = 3'h0,
        BWM_MODE_BLOCKED      = 3'h1,
        BWM_MODE_TEST         = 3'h2,
        BWM_MODE_TEST_BLOCKED = 3'h3,
        BWM_MODE_OFF          = 3'h4
    } bwm_mode_t;

    typedef enum logic [1:0] {
        BWM_STAT_NORMAL = 2'h0,
        BWM_STAT_ALARM1 = 2'h1,
        BWM_STAT_ALARM2 = 2'h2
    } bwm_stat_t;

    // Base-2 logarithm with 8 fraction bits, mantissa taken linearly.
    function automatic logic [LOG_W-1:0] bwm_log2(input logic [OPS_W-1:0] x);
        logic [4:0]       p;
        logic [OPS_W-1:0] n;
        p = 5'h00;
        for (int i = 0; i < OPS_W; i++) begin
            if (x[i]) begin
                p = 5'(i);
            end
        end
        n = x << (5'h11 - p);
        return {p, n[16:9]};
    endfunction

    // Inverse of bwm_log2, fraction part taken linearly; saturates.
    function automatic logic [OPS_W-1:0] bwm_exp2(input logic [NUM_W-1:0] e);
        logic [26:0] m;
        m = 27'h0000000;
        if (e[25:13] != 13'h0000 || e[12:8] >= EXP_INT_LIMIT) begin
            return DEDUCT_SAT;
        end
        m = 27'({1'b1, e[7:0]}) << e[12:8];
        return m[25:8];
    endfunction

endpackage
`default_nettype wire

//--- design/bwm_wear_calc.sv
// Per-phase computation of life operations consumed by one interruption.
`timescale 1ns/1ps
`default_nettype none
module bwm_wear_calc
    import bwm_pkg::*;
(
    // Clock and reset
    input  wire logic                      clk_sys,
    input  wire logic                      rst,
    // Request
    input  wire logic                      start,
    input  wire logic [bwm_pkg::CUR_W-1:0] current,
    // Breaker characteristic
    input  wire logic [bwm_pkg::CUR_W-1:0] cur_low,
    input  wire logic [bwm_pkg::CUR_W-1:0] cur_high,
    input  wire logic [bwm_pkg::OPS_W-1:0] ops_low,
    input  wire logic [bwm_pkg::OPS_W-1:0] ops_high,
    // Answer
    output logic                           busy,
    output logic                           done,
    output logic [bwm_pkg::OPS_W-1:0]      deduct
);
    typedef enum logic [1:0] {
        BWM_C_IDLE = 2'h0,
        BWM_C_DIV  = 2'h1,
        BWM_C_EXP  = 2'h2,
        BWM_C_DONE = 2'h3
    } bwm_calc_t;

    bwm_calc_t        state_reg;
    logic [LOG_W-1:0] l_cur, l_clo, l_chi, l_olo, l_ohi;
    logic [NUM_W-1:0] num_reg, quo_reg;
    logic [LOG_W-1:0] den_reg, rem_reg;
    logic [LOG_W:0]   trial;
    logic             fits;
    logic [4:0]       step_reg;
    logic             flat;

    assign l_cur = bwm_log2({4'h0, current});
    assign l_clo = bwm_log2({4'h0, cur_low});
    assign l_chi = bwm_log2({4'h0, cur_high});
    assign l_olo = bwm_log2(ops_low);
    assign l_ohi = bwm_log2(ops_high);
    // At or below the low point, or a degenerate characteristic, costs one operation.
    assign flat  = (l_cur <= l_clo) || (l_chi <= l_clo) || (l_olo <= l_ohi);
    assign trial = {rem_reg, num_reg[NUM_W-1]};
    assign fits  = trial >= {1'b0, den_reg};
    assign busy  = state_reg != BWM_C_IDLE;
    assign done  = state_reg == BWM_C_DONE;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg <= BWM_C_IDLE;
            step_reg  <= 5'h00;
            num_reg   <= '0;
            den_reg   <= '0;
            rem_reg   <= '0;
            quo_reg   <= '0;
            deduct    <= DEDUCT_ONE;
        end else begin
            unique case (state_reg)
                BWM_C_IDLE: begin
                    if (start && flat) begin
                        deduct    <= DEDUCT_ONE;
                        state_reg <= BWM_C_DONE;
                    end else if (start) begin
                        // Slope on log axes: exponent = dI * dOps / dImax.
                        num_reg   <= NUM_W'(l_cur - l_clo) * NUM_W'(l_olo - l_ohi);
                        den_reg   <= l_chi - l_clo;
                        rem_reg   <= '0;
                        quo_reg   <= '0;
                        step_reg  <= 5'h00;
                        state_reg <= BWM_C_DIV;
                    end
                end
                BWM_C_DIV: begin
                    rem_reg   <= fits ? LOG_W'(trial - {1'b0, den_reg}) : trial[LOG_W-1:0];
                    quo_reg   <= {quo_reg[NUM_W-2:0], fits};
                    num_reg   <= {num_reg[NUM_W-2:0], 1'b0};
                    step_reg  <= step_reg + 5'h01;
                    if (step_reg == DIV_LAST) begin
                        state_reg <= BWM_C_EXP;
                    end
                end
                BWM_C_EXP: begin
                    deduct    <= bwm_exp2(quo_reg);
                    state_reg <= BWM_C_DONE;
                end
                BWM_C_DONE: begin
                    state_reg <= BWM_C_IDLE;
                end
            endcase
        end
    end

    AST_CALC_BOUND: assert property (@(posedge clk_sys) disable iff (rst)
        (start && !busy) |-> ##[1:28] done)
        else $error("calc did not finish in 28 cycles");

    AST_CALC_FLOOR: assert property (@(posedge clk_sys) disable iff (rst)
        (start && !busy && current <= cur_low) |=> (done && deduct == DEDUCT_ONE))
        else $error("current at or below low point must cost one operation");

endmodule
`default_nettype wire

//--- design/bwm_breaker_wear_monitor.sv
// Breaker wear monitor: trip capture, per-phase life deduction, alarms, counters.
`timescale 1ns/1ps
`default_nettype none
module bwm_breaker_wear_monitor
    import bwm_pkg::*;
#(
    parameter int N_OUT = 8
)(
    // Clock and reset
    input  wire logic                      clk_sys,
    input  wire logic                      rst,
    // Breaker open command outputs of the relay
    input  wire logic [N_OUT-1:0]          open_cmd,
    // Fundamental phase currents, 0.01 kA units, measurement side one
    input  wire logic [bwm_pkg::CUR_W-1:0] phase_a_current_fundamental_s1,
    input  wire logic [bwm_pkg::CUR_W-1:0] phase_b_current_fundamental_s1,
    input  wire logic [bwm_pkg::CUR_W-1:0] phase_c_current_fundamental_s1,
    // Fundamental phase currents, measurement side two
    input  wire logic [bwm_pkg::CUR_W-1:0] phase_a_current_fundamental_s2,
    input  wire logic [bwm_pkg::CUR_W-1:0] phase_b_current_fundamental_s2,
    input  wire logic [bwm_pkg::CUR_W-1:0] phase_c_current_fundamental_s2,
    // Static settings, taken on cfg_load_static
    input  wire logic                      cfg_load_static,
    input  wire bwm_pkg::bwm_mode_t        cfg_mode,
    input  wire bwm_pkg::bwm_stat_t        cfg_force,
    input  wire logic                      cfg_side,
    input  wire logic [bwm_pkg::SEL_W-1:0] cfg_trip_sel,
    // Setting group values, taken on cfg_load_group
    input  wire logic                      cfg_load_group,
    input  wire logic [bwm_pkg::OPS_W-1:0] cfg_ops_low,
    input  wire logic [bwm_pkg::OPS_W-1:0] cfg_ops_high,
    input  wire logic [bwm_pkg::CUR_W-1:0] cfg_characteristic_current_low,
    input  wire logic [bwm_pkg::CUR_W-1:0] cfg_characteristic_current_high,
    input  wire logic                      cfg_alarm1_en,
    input  wire logic [bwm_pkg::OPS_W-1:0] cfg_alarm1_thr,
    input  wire logic                      cfg_alarm2_en,
    input  wire logic [bwm_pkg::OPS_W-1:0] cfg_alarm2_thr,
    // Maintenance commands
    input  wire logic                      life_reload,
    input  wire logic                      counters_clear,
    // Status
    output logic                           alarm1,
    output logic                           alarm2,
    output bwm_pkg::bwm_stat_t             condition,
    output bwm_pkg::bwm_mode_t             block_operating_mode,
    output logic                           test_active,
    output logic                           evaluation_busy,
    output logic [bwm_pkg::OPS_W-1:0]      remaining_phase_a,
    output logic [bwm_pkg::OPS_W-1:0]      remaining_phase_b,
    output logic [bwm_pkg::OPS_W-1:0]      remaining_phase_c,
    output logic [bwm_pkg::CNT_W-1:0]      open_op_count,
    output logic [bwm_pkg::CNT_W-1:0]      alarm1_count,
    output logic [bwm_pkg::CNT_W-1:0]      alarm2_count
);
    bwm_stat_t        force_reg;
    logic             side_reg;
    logic [SEL_W-1:0] trip_sel_reg;
    logic [OPS_W-1:0] ops_low_reg, ops_high_reg, thr1_reg, thr2_reg;
    logic [CUR_W-1:0] cur_low_reg, cur_high_reg;
    logic             en1_reg, en2_reg;
    logic             open_prev_reg, start_reg, trigger, operating;
    logic             below1, below2, alarm1_next, alarm2_next;
    logic [CUR_W-1:0] cur_sel [3];
    logic [CUR_W-1:0] cap_reg [3];
    logic [OPS_W-1:0] rem_reg [3];
    logic [OPS_W-1:0] deduct  [3];
    logic [2:0]       calc_busy, calc_done, low1, low2;

    // Static settings have their own load strobe; a group switch never reaches them.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            block_operating_mode <= BWM_MODE_ON;
            force_reg            <= BWM_STAT_NORMAL;
            side_reg             <= SIDE_RST;
            trip_sel_reg         <= TRIP_SEL_RST;
        end else if (cfg_load_static) begin
            block_operating_mode <= cfg_mode;
            force_reg            <= cfg_force;
            side_reg             <= cfg_side;
            trip_sel_reg         <= cfg_trip_sel;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ops_low_reg  <= OPS_LOW_RST;
            ops_high_reg <= OPS_HIGH_RST;
            cur_low_reg  <= CUR_LOW_RST;
            cur_high_reg <= CUR_HIGH_RST;
            en1_reg      <= 1'b0;
            thr1_reg     <= ALARM1_THR_RST;
            en2_reg      <= 1'b0;
            thr2_reg     <= ALARM2_THR_RST;
        end else if (cfg_load_group) begin
            ops_low_reg  <= cfg_ops_low;
            ops_high_reg <= cfg_ops_high;
            cur_low_reg  <= cfg_characteristic_current_low;
            cur_high_reg <= cfg_characteristic_current_high;
            en1_reg      <= cfg_alarm1_en;
            thr1_reg     <= cfg_alarm1_thr;
            en2_reg      <= cfg_alarm2_en;
            thr2_reg     <= cfg_alarm2_thr;
        end
    end

    assign operating = block_operating_mode == BWM_MODE_ON
                    || block_operating_mode == BWM_MODE_TEST;
    assign test_active = block_operating_mode == BWM_MODE_TEST
                      || block_operating_mode == BWM_MODE_TEST_BLOCKED;

    // Fundamental currents of the chosen measurement side.
    assign cur_sel[0] = side_reg ? phase_a_current_fundamental_s2
                                 : phase_a_current_fundamental_s1;
    assign cur_sel[1] = side_reg ? phase_b_current_fundamental_s2
                                 : phase_b_current_fundamental_s1;
    assign cur_sel[2] = side_reg ? phase_c_current_fundamental_s2
                                 : phase_c_current_fundamental_s1;

    // An open edge arriving while a previous evaluation runs is not counted.
    assign trigger = open_cmd[trip_sel_reg] && !open_prev_reg
                  && operating && !evaluation_busy;
    assign evaluation_busy = start_reg || (|calc_busy);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            open_prev_reg <= 1'b0;
            start_reg     <= 1'b0;
            cap_reg       <= '{default: '0};
        end else begin
            open_prev_reg <= open_cmd[trip_sel_reg];
            start_reg     <= trigger;
            if (trigger) begin
                cap_reg <= cur_sel;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_phase
            bwm_wear_calc u_calc (
                .clk_sys (clk_sys),
                .rst     (rst),
                .start   (start_reg),
                .current (cap_reg[g]),
                .cur_low (cur_low_reg),
                .cur_high(cur_high_reg),
                .ops_low (ops_low_reg),
                .ops_high(ops_high_reg),
                .busy    (calc_busy[g]),
                .done    (calc_done[g]),
                .deduct  (deduct[g])
            );

            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    rem_reg[g] <= OPS_LOW_RST;
                end else if (life_reload) begin
                    rem_reg[g] <= ops_low_reg;
                end else if (calc_done[g]) begin
                    rem_reg[g] <= (deduct[g] >= rem_reg[g]) ? '0
                                : rem_reg[g] - deduct[g];
                end
            end

            assign low1[g] = rem_reg[g] < thr1_reg;
            assign low2[g] = rem_reg[g] < thr2_reg;
        end
    endgenerate

    assign remaining_phase_a = rem_reg[0];
    assign remaining_phase_b = rem_reg[1];
    assign remaining_phase_c = rem_reg[2];

    assign below1 = |low1;
    assign below2 = |low2;
    assign alarm1_next = (operating && en1_reg && below1)
                      || (block_operating_mode != BWM_MODE_OFF
                          && force_reg == BWM_STAT_ALARM1);
    assign alarm2_next = (operating && en2_reg && below2)
                      || (block_operating_mode != BWM_MODE_OFF
                          && force_reg == BWM_STAT_ALARM2);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            alarm1    <= 1'b0;
            alarm2    <= 1'b0;
            condition <= BWM_STAT_NORMAL;
        end else begin
            alarm1    <= alarm1_next;
            alarm2    <= alarm2_next;
            condition <= alarm2_next ? BWM_STAT_ALARM2
                       : alarm1_next ? BWM_STAT_ALARM1 : BWM_STAT_NORMAL;
        end
    end

    // A count event in the clearing cycle survives as a count of one.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            open_op_count <= '0;
            alarm1_count  <= '0;
            alarm2_count  <= '0;
        end else begin
            if (trigger) begin
                open_op_count <= counters_clear ? CNT_ONE : open_op_count + CNT_ONE;
            end else if (counters_clear) begin
                open_op_count <= '0;
            end
            if (alarm1_next && !alarm1) begin
                alarm1_count <= counters_clear ? CNT_ONE : alarm1_count + CNT_ONE;
            end else if (counters_clear) begin
                alarm1_count <= '0;
            end
            if (alarm2_next && !alarm2) begin
                alarm2_count <= counters_clear ? CNT_ONE : alarm2_count + CNT_ONE;
            end else if (counters_clear) begin
                alarm2_count <= '0;
            end
        end
    end

    sequence s_open_edge;
        trigger;
    endsequence

    sequence s_evaluating;
        evaluation_busy ##1 (|calc_busy);
    endsequence

    AST_TRIG_START: assert property (@(posedge clk_sys) disable iff (rst)
        s_open_edge |=> s_evaluating)
        else $error("open edge did not start an evaluation");

    AST_CAPTURE: assert property (@(posedge clk_sys) disable iff (rst)
        s_open_edge |=> (cap_reg[0] == $past(cur_sel[0]) && cap_reg[2] == $past(cur_sel[2])))
        else $error("phase currents not captured at the open edge");

    AST_SIDE_MUX: assert property (@(posedge clk_sys) disable iff (rst)
        side_reg |-> cur_sel[1] == phase_b_current_fundamental_s2)
        else $error("side two selected but side one current used");

    AST_RESET_DEFAULTS: assert property (@(posedge clk_sys)
        rst |=> (block_operating_mode == BWM_MODE_ON && !side_reg
                 && ops_low_reg == OPS_LOW_RST && cur_high_reg == CUR_HIGH_RST))
        else $error("settings did not reset to defaults");

    AST_FORCE: assert property (@(posedge clk_sys) disable iff (rst)
        (force_reg == BWM_STAT_ALARM2 && block_operating_mode != BWM_MODE_OFF
         && !cfg_load_static) |=> (alarm2 && condition == BWM_STAT_ALARM2))
        else $error("forced alarm two not shown");

    AST_STATIC: assert property (@(posedge clk_sys) disable iff (rst)
        (cfg_load_group && !cfg_load_static) |=> $stable(block_operating_mode) && $stable(side_reg))
        else $error("group load changed a static setting");

    AST_ALARM1: assert property (@(posedge clk_sys) disable iff (rst)
        (operating && en1_reg && rem_reg[1] < thr1_reg) |=> alarm1)
        else $error("alarm one missed with a phase below threshold");

    AST_ALARM2_QUIET: assert property (@(posedge clk_sys) disable iff (rst)
        (!en2_reg && force_reg != BWM_STAT_ALARM2 && !cfg_load_static) |=> !alarm2)
        else $error("disabled alarm two asserted");

    AST_OPCOUNT: assert property (@(posedge clk_sys) disable iff (rst)
        (trigger && !counters_clear) |=> open_op_count == $past(open_op_count) + CNT_ONE)
        else $error("open counter did not step by one");

    AST_DEDUCT: assert property (@(posedge clk_sys) disable iff (rst)
        (calc_done[0] && !life_reload && deduct[0] < rem_reg[0])
        |=> rem_reg[0] == $past(rem_reg[0]) - $past(deduct[0]))
        else $error("phase a deduction wrong");

    AST_SATURATE: assert property (@(posedge clk_sys) disable iff (rst)
        (calc_done[2] && !life_reload && deduct[2] >= rem_reg[2]) |=> rem_reg[2] == '0)
        else $error("phase c count did not stop at zero");

endmodule
`default_nettype wire

//--- test/bwm_meas_model.sv
// Stand-in for the relay's phase current measurement and breaker open command outputs.
`timescale 1ns/1ps
`default_nettype none
module bwm_meas_model
    import bwm_pkg::*;
(
    // Clock
    input  wire logic                      clk_sys,
    // Open command outputs and phase currents of both measurement sides
    output logic [7:0]                     open_cmd,
    output logic [bwm_pkg::CUR_W-1:0]      cur_s1 [0:2],
    output logic [bwm_pkg::CUR_W-1:0]      cur_s2 [0:2]
);
    import bwm_pkg::*;

    initial begin
        open_cmd = 8'h00;
        cur_s1 = '{default: 14'h0000};
        cur_s2 = '{default: 14'h0000};
    end

    // Currents are levels that hold until the next change.
    task automatic set_cur(input logic sd, input logic [CUR_W-1:0] a, b, c);
        @(posedge clk_sys);
        if (sd) begin
            cur_s2 <= '{a, b, c};
        end else begin
            cur_s1 <= '{a, b, c};
        end
    endtask

    // The command is a three-cycle pulse, low between openings so each one forms an edge.
    task automatic open_breaker(input int idx);
        @(posedge clk_sys);
        open_cmd[idx] <= 1'b1;
        repeat (3) @(posedge clk_sys);
        open_cmd <= 8'h00;
    endtask
endmodule
`default_nettype wire

//--- test/tb_top.sv
// Self-checking bench for the breaker wear monitor.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import bwm_pkg::*;
    logic              clk_sys, rst, ld_s, ld_g, side, e1, e2, reload, clr;
    logic              a1, a2, tact, busy;
    logic [7:0]        open_cmd;
    logic [2:0]        tsel;
    logic [CUR_W-1:0]  s1 [0:2];
    logic [CUR_W-1:0]  s2 [0:2];
    logic [CUR_W-1:0]  cl, ch;
    logic [OPS_W-1:0]  ol, oh, t1, t2, ra, rb, rc;
    logic [CNT_W-1:0]  nop, n1, n2;
    bwm_mode_t         mode, bmode;
    bwm_stat_t         frc, cond;
    int                failures = 0;
    int                n_tests = 0;
    int                busy_cycles;

    bwm_meas_model u_src (.clk_sys(clk_sys), .open_cmd(open_cmd), .cur_s1(s1), .cur_s2(s2));

    bwm_breaker_wear_monitor #(.N_OUT(8)) u_dut (
        .clk_sys(clk_sys), .rst(rst), .open_cmd(open_cmd),
        .phase_a_current_fundamental_s1(s1[0]), .phase_b_current_fundamental_s1(s1[1]),
        .phase_c_current_fundamental_s1(s1[2]), .phase_a_current_fundamental_s2(s2[0]),
        .phase_b_current_fundamental_s2(s2[1]), .phase_c_current_fundamental_s2(s2[2]),
        .cfg_load_static(ld_s), .cfg_mode(mode), .cfg_force(frc), .cfg_side(side),
        .cfg_trip_sel(tsel), .cfg_load_group(ld_g), .cfg_ops_low(ol), .cfg_ops_high(oh),
        .cfg_characteristic_current_low(cl), .cfg_characteristic_current_high(ch),
        .cfg_alarm1_en(e1), .cfg_alarm1_thr(t1), .cfg_alarm2_en(e2), .cfg_alarm2_thr(t2),
        .life_reload(reload), .counters_clear(clr), .alarm1(a1), .alarm2(a2),
        .condition(cond), .block_operating_mode(bmode), .test_active(tact),
        .evaluation_busy(busy), .remaining_phase_a(ra), .remaining_phase_b(rb),
        .remaining_phase_c(rc), .open_op_count(nop), .alarm1_count(n1), .alarm2_count(n2));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic conclude();
        if (failures == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic rem(input logic [OPS_W-1:0] a, b, c);
        check(ra, a);
        check(rb, b);
        check(rc, c);
    endtask

    task automatic stat(input bwm_mode_t m, input bwm_stat_t f, input logic sd, input int sel);
        @(posedge clk_sys);
        mode <= m;
        frc <= f;
        side <= sd;
        tsel <= 3'(sel);
        ld_s <= 1'b1;
        @(posedge clk_sys);
        ld_s <= 1'b0;
        settle(2);
    endtask

    // Curve points are powers of two so the log-log deductions come out exact.
    task automatic grp(input logic en1, en2, input logic [OPS_W-1:0] th1, th2);
        @(posedge clk_sys);
        e1 <= en1;
        e2 <= en2;
        t1 <= th1;
        t2 <= th2;
        ld_g <= 1'b1;
        @(posedge clk_sys);
        ld_g <= 1'b0;
        settle(2);
    endtask

    task automatic maint(input logic r, input logic c);
        @(posedge clk_sys);
        reload <= r;
        clr <= c;
        @(posedge clk_sys);
        reload <= 1'b0;
        clr <= 1'b0;
        settle(2);
    endtask

    // Counts the edges at which the evaluation is still busy after the command pulse.
    task automatic trip(input int idx);
        u_src.open_breaker(idx);
        busy_cycles = 0;
        while (busy_cycles < 40 && busy !== 1'b0) begin
            @(posedge clk_sys);
            busy_cycles++;
        end
        settle(3);
        check(busy, 1'b0);
    endtask

    task automatic s_reset();
        rem(18'h0c350, 18'h0c350, 18'h0c350);
        check(bmode, BWM_MODE_ON);
        check(cond, BWM_STAT_NORMAL);
        check({a1, a2}, 2'h0);
        check(nop, 32'h0);
    endtask

    task automatic s_low();
        u_src.set_cur(1'b0, 14'h0032, 14'h0032, 14'h0032);
        trip(5);
        check(nop, 32'h0);
        check(busy_cycles, 0);
        trip(0);
        check(nop, 32'h1);
        check(busy_cycles, 1);
        rem(18'h0c34f, 18'h0c34f, 18'h0c34f);
    endtask

    task automatic s_curve();
        grp(1'b0, 1'b0, 18'h003e8, 18'h00064);
        maint(1'b1, 1'b0);
        rem(18'h01000, 18'h01000, 18'h01000);
        u_src.set_cur(1'b0, 14'h0040, 14'h0100, 14'h0400);
        trip(0);
        check(busy_cycles, 28);
        rem(18'h00fff, 18'h00ff0, 18'h00f00);
        u_src.set_cur(1'b1, 14'h0400, 14'h0040, 14'h0100);
        stat(BWM_MODE_ON, BWM_STAT_NORMAL, 1'b1, 3);
        trip(3);
        rem(18'h00eff, 18'h00fef, 18'h00ef0);
    endtask

    task automatic s_modes();
        bwm_mode_t ms [4] = '{BWM_MODE_BLOCKED, BWM_MODE_TEST_BLOCKED, BWM_MODE_OFF,
                             BWM_MODE_TEST};
        foreach (ms[i]) begin
            stat(ms[i], BWM_STAT_NORMAL, 1'b1, 3);
            check(bmode, ms[i]);
            check(tact, ms[i] == BWM_MODE_TEST || ms[i] == BWM_MODE_TEST_BLOCKED);
            trip(3);
            check(nop, 32'(ms[i] == BWM_MODE_TEST) + 32'h3);
        end
        rem(18'h00dff, 18'h00fee, 18'h00ee0);
    endtask

    task automatic s_alarm();
        grp(1'b1, 1'b1, 18'h00e10, 18'h00dff);
        check(bmode, BWM_MODE_TEST);
        check({a1, a2}, 2'h2);
        check(cond, BWM_STAT_ALARM1);
        check(n1, 32'h1);
        trip(3);
        check({a1, a2}, 2'h3);
        check(cond, BWM_STAT_ALARM2);
        check(n2, 32'h1);
        maint(1'b0, 1'b1);
        check(nop | n1 | n2, 32'h0);
        grp(1'b0, 1'b0, 18'h003e8, 18'h00064);
        stat(BWM_MODE_ON, BWM_STAT_ALARM1, 1'b0, 0);
        check({a1, a2}, 2'h2);
        check(cond, BWM_STAT_ALARM1);
        stat(BWM_MODE_BLOCKED, BWM_STAT_ALARM2, 1'b0, 0);
        check({a1, a2}, 2'h1);
        check(cond, BWM_STAT_ALARM2);
        stat(BWM_MODE_OFF, BWM_STAT_ALARM1, 1'b0, 0);
        check({a1, a2}, 2'h0);
    endtask

    task automatic s_sat();
        stat(BWM_MODE_ON, BWM_STAT_NORMAL, 1'b0, 0);
        u_src.set_cur(1'b0, 14'h3fff, 14'h3fff, 14'h3fff);
        trip(0);
        rem(18'h0, 18'h0, 18'h0);
        trip(0);
        rem(18'h0, 18'h0, 18'h0);
        check(nop, 32'h2);
    endtask

    initial begin
        {rst, ld_s, ld_g, side, e1, e2, reload, clr} = 8'h80;
        mode = BWM_MODE_ON;
        frc = BWM_STAT_NORMAL;
        tsel = 3'h0;
        {ol, oh, t1, t2} = {18'h01000, 18'h00010, 18'h003e8, 18'h00064};
        {cl, ch} = {14'h0040, 14'h0400};
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        settle(1);
        s_reset();
        s_low();
        s_curve();
        s_modes();
        s_alarm();
        s_sat();
        conclude();
    end

    initial begin
        repeat (3000) @(posedge clk_sys);
        failures++;
        conclude();
    end
endmodule
`default_nettype wire
